//--- rtl/prom_defines.svh
// Byte codes, field positions and counts of the serial programming protocol.
// Assumes inclusion by bare name from the design file.
`ifndef PROM_DEFINES_SVH
`define PROM_DEFINES_SVH
`define MATCH1        8'h86
`define MATCH2        8'h79
`define OP_WRITE      8'h30
`define OP_ERASE      8'hF0
`define ERR_OPCODE    8'hA1
`define ERR_COMM      8'hA3
`define ERR_OTHER     8'h63
`define ERR_REPEAT    2'h3
`define ACK_OK        8'h55
`define ACK_OVW       8'hAA
`define BLANK         8'hFF
`define SECT_LO       8'h08
`define SECT_HI       8'h0F
`define CHIP_CODE     8'h20
`define FLASH_LO_NIB  4'h8
`define SECT_BYTES    32'h0000_1000
`define CHIP_BYTES    32'h0000_8000
`define PADDR_BYTES   3'h6
`define HEX_TYPE_POS  3'h3
`define HEX_DATA_POS  3'h4
`define HEX_TYPE_END  8'h01
`endif

//--- rtl/prom_pkg.sv
// Types shared by the serial programming interpreter.
// Assumes nothing beyond the constants header.
`default_nettype none
package prom_pkg;
    typedef struct packed {
        logic       valid;
        logic       err;
        logic [7:0] data;
    } rx_t;
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic        erase_sector;
        logic        erase_chip;
        logic [15:0] addr;
        logic [7:0]  data;
    } fl_cmd_t;
endpackage : prom_pkg
`default_nettype wire

//--- rtl/prom_cmd.sv
// Serial programming interpreter: matching, write and erase commands.
// Assumes a byte receiver/transmitter outside and a flash macro with a
// one-cycle read latency and a busy level.
//
// What this block does
// - Erase codes 0x08..0x0F erase the 4K sector named by the low nibble if the top area is not blank and security is off, else go idle.
// - Reserved erase codes 0x00..0x07 and 0x10..0x1F stop and go idle.
// - Erase code 0x20 or above erases the whole array.
// - Sector erase where no flash exists stops and goes idle.
// - First byte 0x86 adjusts baud; echoed on success, silence on error.
// - Second byte 0x79 echoed on success, silence on error.
// - Write opcode 0x30 is echoed when accepted.
// - Failed opcode stage sends one error code three times, then idle.
// - Blank top area skips password authentication and string.
// - Both addresses always sent; a bad one stops and goes idle.
// - Write with security enabled stops and goes idle.
// - Receive error during password addresses or string goes idle.
// - After data, status byte 0x55, or 0xAA on overwrite.
// - Non-blank target location is left unwritten.
// - 16-bit checksum over resulting contents, high byte first.
// - After checksum low byte, wait for the next opcode.
// - Sector erase clears 4K units; codes 0x08..0x0F are sector erase.
// - Whole-array erase clears security; sector erase does not.
`timescale 1ns/1ps
`default_nettype none
`include "prom_defines.svh"
module prom_cmd (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              resetn,
    // Received bytes
    input  wire prom_pkg::rx_t     rx,
    output logic                   rx_ready,
    output logic                   baud_lock,
    // Transmitted bytes
    output logic                   tx_valid,
    output logic [7:0]             tx_data,
    input  wire logic              tx_ready,
    // Flash macro
    output prom_pkg::fl_cmd_t      fl_cmd,
    output logic                   sec_clear,
    input  wire logic [7:0]        fl_rdata,
    input  wire logic              fl_busy,
    // Password and security status
    input  wire logic              top_blank,
    input  wire logic              security_en,
    input  wire logic              pwd_addr_ok,
    input  wire logic              pwd_ok,
    input  wire logic [7:0]        pwd_len,
    output logic [23:0]            pwd_cnt_addr,
    output logic [23:0]            pwd_cmp_addr,
    output logic                   pwd_stb,
    output logic [7:0]             pwd_dat,
    output logic                   idle
);
    typedef enum logic [4:0] {
        S_SYNC1, S_SYNC2, S_OPC, S_ERRTX, S_PADDR, S_PCHK, S_PWD,
        S_PEND, S_ECODE, S_ERASE, S_EWAIT, S_HEX, S_RD, S_CMP, S_STAT,
        S_CKH, S_CKL, S_IDLE
    } state_t;

    state_t             st_ff, nxt_st;
    logic               tx_vld_ff, nxt_tx_vld;
    logic [7:0]         tx_dat_ff, nxt_tx_dat;
    logic [7:0]         cnt_ff, nxt_cnt;
    logic [2:0]         idx_ff, nxt_idx;
    logic [7:0]         len_ff, nxt_len;
    logic [7:0]         typ_ff, nxt_typ;
    logic [15:0]        addr_ff, nxt_addr;
    logic [7:0]         dat_ff, nxt_dat;
    logic [15:0]        sum_ff, nxt_sum;
    logic               ovw_ff, nxt_ovw;
    logic               wr_op_ff, nxt_wr_op;
    logic [7:0]         err_ff, nxt_err;
    logic [47:0]        pa_ff, nxt_pa;
    logic               baud_ff, nxt_baud;
    logic               pstb_ff, nxt_pstb;
    logic [7:0]         pdat_ff, nxt_pdat;
    logic               secc_ff, nxt_secc;
    prom_pkg::fl_cmd_t  fl_ff, nxt_fl;

    // 16-bit wrap-around byte sum
    function automatic logic [15:0] add8(input logic [15:0] s,
                                         input logic [7:0] b);
        add8 = s + {8'h00, b};
    endfunction : add8

    // Low 16 bits of a run of blank bytes
    function automatic logic [15:0] blank_sum(input logic [31:0] n);
        logic [31:0] p;
        p = n * {24'h0, `BLANK};
        blank_sum = p[15:0];
    endfunction : blank_sum

    //------------------------------------------------------------
    // Outputs
    //------------------------------------------------------------
    always_comb begin
        case (st_ff)
            S_SYNC1, S_SYNC2, S_OPC, S_PADDR, S_ECODE:
                rx_ready = !tx_vld_ff;
            // A spent password count hands over without taking a byte
            S_PWD:
                rx_ready = !tx_vld_ff && cnt_ff != 8'h00;
            // Read data stands one cycle only, so no data byte while a write runs
            S_HEX:
                rx_ready = !tx_vld_ff && !fl_busy && !fl_ff.wr;
            default:
                rx_ready = 1'b0;
        endcase
    end

    assign tx_valid     = tx_vld_ff;
    assign tx_data      = tx_dat_ff;
    assign fl_cmd       = fl_ff;
    assign sec_clear    = secc_ff;
    assign baud_lock    = baud_ff;
    assign pwd_cnt_addr = pa_ff[47:24];
    assign pwd_cmp_addr = pa_ff[23:0];
    assign pwd_stb      = pstb_ff;
    assign pwd_dat      = pdat_ff;
    assign idle         = (st_ff == S_IDLE);

    //------------------------------------------------------------
    // Next state
    //------------------------------------------------------------
    always_comb begin
        logic take;
        logic [7:0] d;
        take       = rx.valid && rx_ready;
        d          = rx.data;
        nxt_st     = st_ff;
        nxt_tx_vld = tx_vld_ff && !tx_ready;
        nxt_tx_dat = tx_dat_ff;
        nxt_cnt    = cnt_ff;
        nxt_idx    = idx_ff;
        nxt_len    = len_ff;
        nxt_typ    = typ_ff;
        nxt_addr   = addr_ff;
        nxt_dat    = dat_ff;
        nxt_sum    = sum_ff;
        nxt_ovw    = ovw_ff;
        nxt_wr_op  = wr_op_ff;
        nxt_err    = err_ff;
        nxt_pa     = pa_ff;
        nxt_baud   = 1'b0;
        nxt_pstb   = 1'b0;
        nxt_pdat   = pdat_ff;
        nxt_secc   = 1'b0;
        nxt_fl     = '0;
        nxt_fl.addr = fl_ff.addr;
        nxt_fl.data = fl_ff.data;
        case (st_ff)
            S_SYNC1: begin
                if (take && !rx.err && d == `MATCH1) begin
                    nxt_baud   = 1'b1;
                    nxt_tx_vld = 1'b1;
                    nxt_tx_dat = `MATCH1;
                    nxt_st     = S_SYNC2;
                end
            end
            S_SYNC2: begin
                if (take && !rx.err && d == `MATCH2) begin
                    nxt_tx_vld = 1'b1;
                    nxt_tx_dat = `MATCH2;
                    nxt_st     = S_OPC;
                end
            end
            S_OPC: begin
                if (take) begin
                    nxt_cnt = 8'h00;
                    nxt_idx = 3'h0;
                    nxt_sum = 16'h0000;
                    nxt_ovw = 1'b0;
                    if (rx.err) begin
                        nxt_err = `ERR_COMM;
                        nxt_st  = S_ERRTX;
                    end else if (d == `OP_WRITE || d == `OP_ERASE) begin
                        nxt_wr_op  = (d == `OP_WRITE);
                        nxt_tx_vld = 1'b1;
                        nxt_tx_dat = d;
                        nxt_st     = S_PADDR;
                    end else begin
                        nxt_err = `ERR_OPCODE;
                        nxt_st  = S_ERRTX;
                    end
                end
            end
            S_ERRTX: begin
                if (!tx_vld_ff) begin
                    if (cnt_ff[1:0] == `ERR_REPEAT) begin
                        nxt_st = S_IDLE;
                    end else begin
                        nxt_tx_vld = 1'b1;
                        nxt_tx_dat = err_ff;
                        nxt_cnt    = cnt_ff + 8'h01;
                    end
                end
            end
            S_PADDR: begin
                if (take) begin
                    if (rx.err) begin
                        nxt_st = S_IDLE;
                    end else begin
                        nxt_pa  = {pa_ff[39:0], d};
                        nxt_idx = idx_ff + 3'h1;
                        if (idx_ff == `PADDR_BYTES - 3'h1) begin
                            nxt_st = S_PCHK;
                        end
                    end
                end
            end
            S_PCHK: begin
                nxt_cnt = pwd_len;
                if (!pwd_addr_ok) begin
                    nxt_st = S_IDLE;
                end else if (top_blank) begin
                    nxt_st = S_PEND;
                end else begin
                    nxt_st = S_PWD;
                end
            end
            S_PWD: begin
                if (cnt_ff == 8'h00) begin
                    nxt_st = S_PEND;
                end else if (take) begin
                    if (rx.err) begin
                        nxt_st = S_IDLE;
                    end else begin
                        nxt_pstb = 1'b1;
                        nxt_pdat = d;
                        nxt_cnt  = cnt_ff - 8'h01;
                    end
                end
            end
            S_PEND: begin
                nxt_idx = 3'h0;
                if (!top_blank && !pwd_ok) begin
                    nxt_st = S_IDLE;
                end else if (wr_op_ff && security_en) begin
                    nxt_st = S_IDLE;
                end else if (wr_op_ff) begin
                    nxt_st = S_HEX;
                end else begin
                    nxt_st = S_ECODE;
                end
            end
            S_ECODE: begin
                if (take) begin
                    nxt_dat = d;
                    if (rx.err) begin
                        nxt_st = S_IDLE;
                    end else if (d >= `CHIP_CODE) begin
                        nxt_st = S_ERASE;
                    end else if (d < `SECT_LO || d > `SECT_HI) begin
                        nxt_st = S_IDLE;
                    end else if (d[3:0] < `FLASH_LO_NIB) begin
                        nxt_st = S_IDLE;
                    end else if (top_blank || security_en) begin
                        nxt_st = S_IDLE;
                    end else begin
                        nxt_st = S_ERASE;
                    end
                end
            end
            S_ERASE: begin
                if (!fl_busy) begin
                    nxt_fl.addr = {dat_ff[3:0], 12'h000};
                    if (dat_ff >= `CHIP_CODE) begin
                        nxt_fl.erase_chip = 1'b1;
                        nxt_secc = 1'b1;
                        nxt_sum  = blank_sum(`CHIP_BYTES);
                    end else begin
                        nxt_fl.erase_sector = 1'b1;
                        nxt_sum  = blank_sum(`SECT_BYTES);
                    end
                    nxt_st = S_EWAIT;
                end
            end
            S_EWAIT: begin
                if (!fl_busy && !fl_ff.erase_chip && !fl_ff.erase_sector) begin
                    nxt_st = S_CKH;
                end
            end
            S_HEX: begin
                if (take) begin
                    if (rx.err) begin
                        nxt_st = S_IDLE;
                    end else if (idx_ff == 3'h0) begin
                        nxt_len = d;
                        nxt_idx = 3'h1;
                    end else if (idx_ff < `HEX_TYPE_POS) begin
                        nxt_addr = {addr_ff[7:0], d};
                        nxt_idx  = idx_ff + 3'h1;
                    end else if (idx_ff == `HEX_TYPE_POS) begin
                        nxt_typ = d;
                        nxt_idx = `HEX_DATA_POS;
                    end else if (len_ff != 8'h00) begin
                        nxt_dat     = d;
                        nxt_fl.rd   = 1'b1;
                        nxt_fl.addr = addr_ff;
                        nxt_st      = S_RD;
                    end else if (typ_ff == `HEX_TYPE_END) begin
                        nxt_st = S_STAT;
                    end else begin
                        nxt_idx = 3'h0;
                    end
                end
            end
            S_RD: begin
                nxt_st = S_CMP;
            end
            S_CMP: begin
                if (!fl_busy) begin
                    if (fl_rdata != `BLANK) begin
                        nxt_ovw = 1'b1;
                        nxt_sum = add8(sum_ff, fl_rdata);
                    end else begin
                        nxt_fl.wr   = 1'b1;
                        nxt_fl.data = dat_ff;
                        nxt_sum     = add8(sum_ff, dat_ff);
                    end
                    nxt_addr = addr_ff + 16'h0001;
                    nxt_len  = len_ff - 8'h01;
                    nxt_st   = S_HEX;
                end
            end
            S_STAT: begin
                if (!tx_vld_ff && !fl_busy) begin
                    nxt_tx_vld = 1'b1;
                    nxt_tx_dat = ovw_ff ? `ACK_OVW : `ACK_OK;
                    nxt_st     = S_CKH;
                end
            end
            S_CKH: begin
                if (!tx_vld_ff) begin
                    nxt_tx_vld = 1'b1;
                    nxt_tx_dat = sum_ff[15:8];
                    nxt_st     = S_CKL;
                end
            end
            S_CKL: begin
                if (!tx_vld_ff) begin
                    nxt_tx_vld = 1'b1;
                    nxt_tx_dat = sum_ff[7:0];
                    nxt_st     = S_OPC;
                end
            end
            S_IDLE: begin
                nxt_st = S_IDLE;
            end
            default: begin
                nxt_st = S_IDLE;
            end
        endcase
    end

    //------------------------------------------------------------
    // Registers
    //------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn) begin
            st_ff     <= S_SYNC1;
            tx_vld_ff <= 1'b0;
            tx_dat_ff <= 8'h00;
            cnt_ff    <= 8'h00;
            idx_ff    <= 3'h0;
            len_ff    <= 8'h00;
            typ_ff    <= 8'h00;
            addr_ff   <= 16'h0000;
            dat_ff    <= 8'h00;
            sum_ff    <= 16'h0000;
            ovw_ff    <= 1'b0;
            wr_op_ff  <= 1'b0;
            err_ff    <= 8'h00;
            pa_ff     <= 48'h0;
            baud_ff   <= 1'b0;
            pstb_ff   <= 1'b0;
            pdat_ff   <= 8'h00;
            secc_ff   <= 1'b0;
            fl_ff     <= '0;
        end else begin
            st_ff     <= nxt_st;
            tx_vld_ff <= nxt_tx_vld;
            tx_dat_ff <= nxt_tx_dat;
            cnt_ff    <= nxt_cnt;
            idx_ff    <= nxt_idx;
            len_ff    <= nxt_len;
            typ_ff    <= nxt_typ;
            addr_ff   <= nxt_addr;
            dat_ff    <= nxt_dat;
            sum_ff    <= nxt_sum;
            ovw_ff    <= nxt_ovw;
            wr_op_ff  <= nxt_wr_op;
            err_ff    <= nxt_err;
            pa_ff     <= nxt_pa;
            baud_ff   <= nxt_baud;
            pstb_ff   <= nxt_pstb;
            pdat_ff   <= nxt_pdat;
            secc_ff   <= nxt_secc;
            fl_ff     <= nxt_fl;
        end
    end
endmodule : prom_cmd
`default_nettype wire

//--- dv/prom_cmd_asserts.sv
// Concurrent checks on the serial programming interpreter's ports.
// Assumes one clock with a synchronous active-low reset; bound below.
`timescale 1ns/1ps
`default_nettype none
module prom_cmd_asserts (
    // Clock and reset
    input wire logic              clk,
    input wire logic              resetn,
    // Byte link
    input wire prom_pkg::rx_t     rx,
    input wire logic              rx_ready,
    input wire logic              baud_lock,
    input wire logic              tx_valid,
    input wire logic [7:0]        tx_data,
    input wire logic              tx_ready,
    // Flash side
    input wire prom_pkg::fl_cmd_t fl_cmd,
    input wire logic              sec_clear,
    input wire logic [7:0]        fl_rdata,
    input wire logic              idle
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence rd_blank_s;
        fl_cmd.rd ##1 (fl_rdata == 8'hFF);
    endsequence
    sequence rd_used_s;
        fl_cmd.rd ##1 (fl_rdata != 8'hFF);
    endsequence
    echo_match_a: assert property (baud_lock |-> tx_valid && tx_data == 8'h86
        && $past(rx.valid) && $past(rx_ready) && $past(rx.data) == 8'h86)
        else $error("first match byte not echoed");
    no_take_a: assert property (tx_valid |-> !rx_ready)
        else $error("byte taken while reply pending");
    tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("reply byte dropped before accept");
    idle_sticky_a: assert property (idle |=> idle)
        else $error("idle left without reset");
    idle_quiet_a: assert property (idle |-> !rx_ready && !fl_cmd.wr
        && !fl_cmd.erase_sector && !fl_cmd.erase_chip)
        else $error("activity while idle");
    chip_sec_a: assert property (fl_cmd.erase_chip == sec_clear)
        else $error("security clear not paired with chip erase");
    sector_addr_a: assert property (fl_cmd.erase_sector |-> fl_cmd.addr[15]
        && fl_cmd.addr[11:0] == 12'h000)
        else $error("sector erase address not sector aligned");
    wr_skip_a: assert property (rd_used_s |-> ##1 (!fl_cmd.wr) [*2])
        else $error("write issued on used location");
    wr_blank_a: assert property (rd_blank_s |-> ##[1:40] fl_cmd.wr)
        else $error("write missing on blank location");
endmodule : prom_cmd_asserts
bind prom_cmd prom_cmd_asserts CHK (.clk(clk), .resetn(resetn), .rx(rx),
    .rx_ready(rx_ready), .baud_lock(baud_lock), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .fl_cmd(fl_cmd),
    .sec_clear(sec_clear), .fl_rdata(fl_rdata), .idle(idle));
`default_nettype wire

//--- dv/far_side_model.sv
// Far side model: byte transmitter acceptance and a flash array.
// Assumes the interpreter's one-cycle read latency and busy level.
`timescale 1ns/1ps
`default_nettype none
module far_side_model (
    // Clock and reset
    input wire logic              clk,
    input wire logic              resetn,
    // Link side
    input wire logic              slow,
    output logic                  tx_ready,
    // Flash side
    input wire prom_pkg::fl_cmd_t fl_cmd,
    output logic [7:0]            fl_rdata,
    output logic                  fl_busy
);
    // ----------------------------------------
    // Array and timing
    // ----------------------------------------
    logic [7:0] mem [0:65535];
    logic [2:0] busy_cnt;
    initial begin
        for (int a = 0; a < 65536; a++) mem[a] = 8'hFF;
        tx_ready = 1'b0;
        fl_rdata = 8'h00;
        busy_cnt = 3'h0;
    end
    always @(posedge clk) begin
        tx_ready <= !slow || ($urandom % 3 == 0);
        // Read data only holds one cycle, then shows a changing pattern
        fl_rdata <= fl_cmd.rd ? mem[fl_cmd.addr] : ~fl_rdata;
        if (fl_cmd.wr) mem[fl_cmd.addr] <= fl_cmd.data;
        if (fl_cmd.erase_sector)
            for (int a = 0; a < 4096; a++) mem[{fl_cmd.addr[15:12], 12'(a)}] <= 8'hFF;
        if (fl_cmd.erase_chip)
            for (int a = 32768; a < 65536; a++) mem[a] <= 8'hFF;
        if (fl_cmd.wr || fl_cmd.erase_sector || fl_cmd.erase_chip) busy_cnt <= 3'h4;
        else if (busy_cnt != 3'h0) busy_cnt <= busy_cnt - 3'h1;
    end
    assign fl_busy = (busy_cnt != 3'h0);
endmodule : far_side_model
`default_nettype wire

//--- dv/tb_serial_prom_erase_write_protocol.sv
// Self-checking bench for the serial programming interpreter.
// Assumes the far side model and the bound checker alongside.
`timescale 1ns/1ps
`default_nettype none
module tb_serial_prom_erase_write_protocol;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic              clk, resetn, rx_ready, baud_lock, tx_valid, tx_ready, sec_clear;
    logic              fl_busy, top_blank, security_en, pwd_addr_ok, pwd_ok, idle, slow;
    logic              pwd_stb;
    logic [7:0]        tx_data, fl_rdata, pwd_len, op, d0, pwd_dat;
    logic [15:0]       sum;
    logic [23:0]       pwd_cnt_addr, pwd_cmp_addr;
    logic [7:0]        rec [12];
    logic [7:0]        exp_q [$];
    prom_pkg::rx_t     rx;
    prom_pkg::fl_cmd_t fl_cmd;
    int                n_errors, total_checks;
    prom_cmd DUT (.clk(clk), .resetn(resetn), .rx(rx), .rx_ready(rx_ready),
        .baud_lock(baud_lock), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
        .fl_cmd(fl_cmd), .sec_clear(sec_clear), .fl_rdata(fl_rdata), .fl_busy(fl_busy),
        .top_blank(top_blank), .security_en(security_en), .pwd_addr_ok(pwd_addr_ok),
        .pwd_ok(pwd_ok), .pwd_len(pwd_len), .pwd_cnt_addr(pwd_cnt_addr),
        .pwd_cmp_addr(pwd_cmp_addr), .pwd_stb(pwd_stb), .pwd_dat(pwd_dat), .idle(idle));
    far_side_model FAR (.clk(clk), .resetn(resetn), .slow(slow), .tx_ready(tx_ready),
        .fl_cmd(fl_cmd), .fl_rdata(fl_rdata), .fl_busy(fl_busy));
    always #2 clk = ~clk;
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic cmp(input logic [23:0] got, input logic [23:0] want);
        total_checks++;
        if (got !== want) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, want);
        end
    endtask : cmp
    task automatic results;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : results
    task automatic note(input logic [7:0] b);
        exp_q.push_back(b);
    endtask : note
    // Holds the byte until the edge that takes it, then withdraws it
    task automatic send(input logic [7:0] b, input logic e = 1'b0);
        @(posedge clk);
        #1 rx <= {1'b1, e, b};
        @(negedge clk);
        for (int n = 0; n < 3000 && rx_ready !== 1'b1; n++) @(negedge clk);
        @(posedge clk);
        #1 rx <= '0;
    endtask : send
    task automatic opc(input logic [7:0] b);
        note(b);
        send(b);
    endtask : opc
    task automatic match;
        send(8'h55);
        opc(8'h86);
        opc(8'h79);
    endtask : match
    task automatic addr6;
        logic [47:0] a;
        a = {16'($urandom), $urandom};
        for (int i = 5; i >= 0; i--) send(a[i*8 +: 8]);
        repeat (2) @(posedge clk);
        cmp(pwd_cnt_addr, a[47:24]);
        cmp(pwd_cmp_addr, a[23:0]);
    endtask : addr6
    task automatic settle(input logic want_idle);
        for (int n = 0; n < 3000 && (exp_q.size() != 0 || (want_idle && idle !== 1'b1)); n++)
            @(posedge clk);
        cmp(24'(exp_q.size()), 24'h0);
        cmp({23'h0, idle}, {23'h0, want_idle});
    endtask : settle
    task automatic rst;
        @(posedge clk);
        #1 resetn = 1'b0;
        rx = '0;
        top_blank = 1'b1;
        security_en = 1'b0;
        pwd_addr_ok = 1'b1;
        slow = 1'($urandom);
        repeat (12) @(posedge clk);
        #1 resetn = 1'b1;
        exp_q.delete();
    endtask : rst
    // ----------------------------------------
    // Reply watcher and watchdog
    // ----------------------------------------
    always @(posedge clk) begin
        if (resetn === 1'b1 && tx_valid === 1'b1 && tx_ready === 1'b1) begin
            if (exp_q.size() == 0) cmp({16'h0, tx_data}, 24'hFFFFFF);
            else cmp({16'h0, tx_data}, {16'h0, exp_q.pop_front()});
        end
    end
    initial begin
        repeat (40000) @(posedge clk);
        n_errors++;
        results();
    end
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        resetn = 1'b0;
        rx = '0;
        {top_blank, security_en, pwd_addr_ok, pwd_ok, slow} = 5'b10111;
        pwd_len = 8'h02;
        n_errors = 0;
        total_checks = 0;
        void'($urandom(32'h2f7c));
        rst();
        slow = 1'b1;
        FAR.mem[16'h8001] = 8'h12;
        match();
        opc(8'h30);
        addr6();
        d0 = 8'($urandom);
        sum = 16'(d0) + 16'h0012;
        rec = '{8'h02, 8'h80, 8'h00, 8'h00, d0, 8'h5A, 8'h00,
                8'h00, 8'h00, 8'h00, 8'h01, 8'hFF};
        note(8'hAA);
        note(sum[15:8]);
        note(sum[7:0]);
        foreach (rec[i]) send(rec[i]);
        settle(1'b0);
        cmp({16'h0, FAR.mem[16'h8000]}, {16'h0, d0});
        cmp({16'h0, FAR.mem[16'h8001]}, 24'h12);
        opc(8'hF0);
        addr6();
        note(8'h80);
        note(8'h00);
        send(8'h20 + 8'($urandom % 224));
        settle(1'b0);
        cmp({16'h0, FAR.mem[16'h8000]}, 24'hFF);
        rst();
        top_blank = 1'b0;
        FAR.mem[16'hA123] = 8'h00;
        FAR.mem[16'hB000] = 8'h00;
        match();
        opc(8'hF0);
        addr6();
        repeat (2) begin
            op = 8'($urandom);
            send(op);
            cmp({15'h0, pwd_stb, pwd_dat}, {15'h0, 1'b1, op});
        end
        note(8'hF0);
        note(8'h00);
        send(8'h0A);
        settle(1'b0);
        cmp({16'h0, FAR.mem[16'hA123]}, 24'hFF);
        cmp({16'h0, FAR.mem[16'hB000]}, 24'h00);
        for (int i = 0; i < 8; i++) begin
            rst();
            security_en = (i == 2);
            pwd_addr_ok = (i != 3);
            match();
            op = 8'($urandom);
            if (op == 8'h30 || op == 8'hF0) op = 8'h11;
            case (i)
                0: begin
                    repeat (3) note(8'hA1);
                    send(op);
                end
                1: begin
                    repeat (3) note(8'hA3);
                    send(8'h30, 1'b1);
                end
                2, 3: begin
                    opc(8'h30);
                    addr6();
                end
                4: begin
                    opc(8'h30);
                    send(8'h00);
                    send(8'h00, 1'b1);
                end
                default: begin
                    opc(8'hF0);
                    addr6();
                    send(i[0] ? 8'h10 + 8'(op % 16) : 8'(op % 8));
                end
            endcase
            settle(1'b1);
        end
        results();
    end
endmodule : tb_serial_prom_erase_write_protocol
`default_nettype wire
